//--- serial_if.v
/*
 Clock-synchronous 8-bit serial interface with an AXI4-Lite register slave,
 sticky interrupt status with enable and clear registers, and one level
 interrupt output.
 Assumes one clock aclk with one aclk cycle per instruction cycle; the serial
 clock and data input pins come from outside and are synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none
`include "serial_if_defines.vh"

module serial_if #(
   parameter ADDR_W = 12
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite write address
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // serial clock pin, output enable low while driven
   input wire serial_clock_pin_in,
   output wire serial_clock_pin_out,
   output wire serial_clock_pin_oe_n,
   // serial data pins
   input wire serial_in_pin,
   output reg serial_out_pin,
   output wire serial_out_pin_oe_n,
   // interrupt
   output wire irq
);

   localparam ST_START_WAIT = 2'h0;
   localparam ST_CLOCK_WAIT = 2'h1;
   localparam ST_TRANSFER = 2'h2;
   localparam ST_CONT_CLOCK = 2'h3;

   // registers
   reg [3:0] serial_port_pin_mode_reg;
   reg [3:0] serial_clock_mode_a_reg;
   reg [3:0] mode_a_delay_reg;
   reg [3:0] mode_a_eff_reg;
   reg [3:0] serial_clock_mode_b_reg;
   reg [3:0] miscellaneous_control_reg;
   reg [7:0] shift_data_reg;
   reg [3:0] irq_status_reg;
   reg [3:0] irq_enable_reg;
   reg [1:0] state_reg;
   reg [2:0] bit_transfer_counter_reg;

   // bus handshake state
   reg aw_held_reg;
   reg w_held_reg;
   reg [ADDR_W-1:0] aw_addr_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;

   // pin synchronisers
   reg sck_meta_reg;
   reg sck_sync_reg;
   reg sck_prev_reg;
   reg si_meta_reg;
   reg si_sync_reg;

   wire wr_fire;
   wire rd_fire;
   wire [ADDR_W-1:0] wr_index;
   wire [ADDR_W-1:0] rd_index;
   wire wr_lane;
   wire [3:0] wr_nibble;
   wire wr_mode_a;
   wire wr_start;
   wire internal_src;
   wire clock_pin_serial;
   wire gen_enable;
   wire gen_level;
   wire gen_fall;
   wire gen_rise;
   wire clk_fall;
   wire clk_rise;
   wire cont_mode;
   wire tx_enabled;
   wire rx_enabled;
   wire in_transfer;
   wire done_event;
   wire abort_event;
   wire flag_event;
   reg [31:0] rd_value;
   reg rd_mapped;

   // ---------------- axi4-lite slave ----------------
   assign s_axi_awready = !aw_held_reg;
   assign s_axi_wready = !w_held_reg;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign wr_index = {2'b00, aw_addr_reg[ADDR_W-1:2]};
   assign rd_index = {2'b00, s_axi_araddr[ADDR_W-1:2]};
   assign wr_lane = w_strb_reg[0];
   assign wr_nibble = w_data_reg[3:0];

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= {ADDR_W{1'b0}};
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (wr_index)
               `IDX_PIN_MODE, `IDX_MODE_A, `IDX_DATA_LOW, `IDX_DATA_HIGH,
               `IDX_MISC, `IDX_MODE_B, `IDX_START, `IDX_IRQ_ENABLE,
               `IDX_IRQ_CLEAR: s_axi_bresp <= `RESP_OKAY;
               default: s_axi_bresp <= `RESP_SLVERR;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // write-only registers read as zero
   always @* begin
      rd_value = 32'h00000000;
      rd_mapped = 1'b1;
      case (rd_index)
         `IDX_PIN_MODE, `IDX_MODE_A, `IDX_START, `IDX_IRQ_CLEAR: rd_value = 32'h00000000;
         `IDX_DATA_LOW: rd_value = {28'h0000000, shift_data_reg[3:0]};
         `IDX_DATA_HIGH: rd_value = {28'h0000000, shift_data_reg[7:4]};
         `IDX_MISC: rd_value = {28'h0000000, miscellaneous_control_reg};
         `IDX_MODE_B: rd_value = {28'h0000000, serial_clock_mode_b_reg};
         `IDX_IRQ_STATUS: rd_value = {28'h0000000, irq_status_reg};
         `IDX_IRQ_ENABLE: rd_value = {28'h0000000, irq_enable_reg};
         default: rd_mapped = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_value;
         s_axi_rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------- control registers ----------------
   assign wr_mode_a = wr_fire && wr_lane && (wr_index == `IDX_MODE_A);
   assign wr_start = wr_fire && wr_lane && (wr_index == `IDX_START);

   always @(posedge aclk) begin
      if (!aresetn) begin
         serial_port_pin_mode_reg <= `RST_NIBBLE;
         serial_clock_mode_a_reg <= `RST_NIBBLE;
         mode_a_delay_reg <= `RST_NIBBLE;
         mode_a_eff_reg <= `RST_NIBBLE;
         serial_clock_mode_b_reg <= `RST_NIBBLE;
         miscellaneous_control_reg <= `RST_NIBBLE;
         irq_enable_reg <= `RST_NIBBLE;
      end else begin
         // the written mode reaches the logic two cycles later
         mode_a_delay_reg <= serial_clock_mode_a_reg;
         mode_a_eff_reg <= mode_a_delay_reg;
         if (wr_fire && wr_lane) begin
            case (wr_index)
               `IDX_PIN_MODE: serial_port_pin_mode_reg <= wr_nibble;
               `IDX_MODE_A: serial_clock_mode_a_reg <= wr_nibble;
               `IDX_MODE_B: serial_clock_mode_b_reg <= wr_nibble;
               `IDX_MISC: miscellaneous_control_reg <= wr_nibble;
               `IDX_IRQ_ENABLE: irq_enable_reg <= wr_nibble;
               default: ;
            endcase
         end
      end
   end

   // ---------------- pins and transmit clock ----------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         sck_meta_reg <= 1'b1;
         sck_sync_reg <= 1'b1;
         sck_prev_reg <= 1'b1;
         si_meta_reg <= 1'b0;
         si_sync_reg <= 1'b0;
      end else begin
         sck_meta_reg <= serial_clock_pin_in;
         sck_sync_reg <= sck_meta_reg;
         sck_prev_reg <= sck_sync_reg;
         si_meta_reg <= serial_in_pin;
         si_sync_reg <= si_meta_reg;
      end
   end

   assign clock_pin_serial = mode_a_eff_reg[`MODE_A_PIN_BIT];
   assign internal_src = mode_a_eff_reg[2:0] != `SRC_EXTERNAL;
   assign tx_enabled = serial_port_pin_mode_reg[`PIN_MODE_TX_BIT];
   assign rx_enabled = serial_port_pin_mode_reg[`PIN_MODE_RX_BIT];
   assign cont_mode = serial_port_pin_mode_reg[1:0] == `OPMODE_CONT_CLOCK;
   assign gen_enable = clock_pin_serial && internal_src && (state_reg != ST_START_WAIT);

   transmit_clock_gen #(
      .CNT_W(13)
   ) clock_gen (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(gen_enable),
      .select(mode_a_eff_reg[2:0]),
      .range(serial_clock_mode_b_reg[`MODE_B_RANGE_BIT]),
      .clock_level(gen_level),
      .fall_pulse(gen_fall),
      .rise_pulse(gen_rise)
   );

   // clock edges from the chosen source; none while the pin is not serial
   assign clk_fall = clock_pin_serial &&
      (internal_src ? gen_fall : (sck_prev_reg && !sck_sync_reg));
   assign clk_rise = clock_pin_serial &&
      (internal_src ? gen_rise : (!sck_prev_reg && sck_sync_reg));

   assign serial_clock_pin_out = gen_level;
   assign serial_clock_pin_oe_n = !(clock_pin_serial && internal_src);
   assign serial_out_pin_oe_n = !tx_enabled;

   // ---------------- transfer state machine ----------------
   assign in_transfer = state_reg == ST_TRANSFER;
   assign done_event = in_transfer && clk_rise &&
      (bit_transfer_counter_reg == `LAST_BIT_COUNT);
   assign abort_event = in_transfer && (wr_mode_a || wr_start);
   assign flag_event = done_event || abort_event;

   always @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= ST_START_WAIT;
         bit_transfer_counter_reg <= 3'h0;
      end else if (wr_mode_a) begin
         state_reg <= ST_START_WAIT;
         bit_transfer_counter_reg <= 3'h0;
      end else if (wr_start) begin
         state_reg <= ST_CLOCK_WAIT;
         bit_transfer_counter_reg <= 3'h0;
      end else begin
         case (state_reg)
            ST_START_WAIT: ;
            ST_CLOCK_WAIT: begin
               if (clk_fall) begin
                  if (cont_mode && internal_src) begin
                     state_reg <= ST_CONT_CLOCK;
                  end else begin
                     state_reg <= ST_TRANSFER;
                  end
               end
            end
            ST_TRANSFER: begin
               if (clk_rise) begin
                  bit_transfer_counter_reg <= bit_transfer_counter_reg + 3'h1;
                  if (done_event) begin
                     bit_transfer_counter_reg <= 3'h0;
                     state_reg <= internal_src ? ST_START_WAIT : ST_CLOCK_WAIT;
                  end
               end
            end
            ST_CONT_CLOCK: ;
            default: state_reg <= ST_START_WAIT;
         endcase
      end
   end

   // ---------------- shift register and output pin ----------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         shift_data_reg <= `RST_DATA;
         serial_out_pin <= `RST_SERIAL_OUT;
      end else begin
         if (state_reg == ST_START_WAIT) begin
            serial_out_pin <= serial_clock_mode_b_reg[`MODE_B_IDLE_BIT];
         end else if (clk_fall && !(state_reg == ST_CLOCK_WAIT && cont_mode && internal_src)
                      && state_reg != ST_CONT_CLOCK) begin
            serial_out_pin <= shift_data_reg[0];
         end
         if (in_transfer && clk_rise && !wr_mode_a && !wr_start) begin
            shift_data_reg <= {rx_enabled & si_sync_reg, shift_data_reg[7:1]};
         end else if (wr_fire && wr_lane && wr_index == `IDX_DATA_LOW) begin
            shift_data_reg[3:0] <= wr_nibble;
         end else if (wr_fire && wr_lane && wr_index == `IDX_DATA_HIGH) begin
            shift_data_reg[7:4] <= wr_nibble;
         end
      end
   end

   // ---------------- interrupt status ----------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_reg <= `RST_NIBBLE;
      end else begin
         if (wr_fire && wr_lane && wr_index == `IDX_IRQ_CLEAR) begin
            irq_status_reg <= irq_status_reg & ~wr_nibble;
         end
         // a new event wins over a clear in the same cycle
         if (flag_event) begin
            irq_status_reg[`DONE_FLAG_BIT] <= 1'b1;
         end
      end
   end

   assign irq = |(irq_status_reg & irq_enable_reg);

endmodule // serial_if

`default_nettype wire

//--- serial_if_asserts.sv
/*
 checker for serial_if: bus handshakes, responses and the data out pin enable.
 assumes binding to the serial_if ports and full write strobes.
*/
`timescale 1ns/1ns
`default_nettype none
`include "serial_if_defines.vh"
module serial_if_asserts #(
   parameter ADDR_W = 12
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write channels
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read channels
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // pins
   input wire logic serial_out_pin_oe_n,
   input wire logic irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [ADDR_W-1:0] wa_reg;
   logic [ADDR_W-1:0] ra_reg;
   logic wd0_reg;
   // 0 unmapped, 1 write-only, 2 readable
   function automatic logic [1:0] kind(input logic [ADDR_W-1:0] a);
      if (a[1:0] != 2'h0) return 2'h0;
      case (a[ADDR_W-1:2])
         `IDX_PIN_MODE, `IDX_MODE_A, `IDX_START, `IDX_IRQ_CLEAR: return 2'h1;
         `IDX_DATA_LOW, `IDX_DATA_HIGH, `IDX_MISC, `IDX_MODE_B: return 2'h2;
         `IDX_IRQ_STATUS, `IDX_IRQ_ENABLE: return 2'h2;
         default: return 2'h0;
      endcase
   endfunction
   always @(posedge aclk) begin
      if (s_axi_awvalid && s_axi_awready) wa_reg <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd0_reg <= s_axi_wdata[0];
      if (s_axi_arvalid && s_axi_arready) ra_reg <= s_axi_araddr;
   end
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence b_waiting;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   a_bresp_held: assert property (b_waiting |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data missing");
   a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
      else $error("read data changed");
   a_arready_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while busy");
   a_bresp_map: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp ==
      ((kind(wa_reg) != 2'h0 && wa_reg[ADDR_W-1:2] != `IDX_IRQ_STATUS) ?
      `RESP_OKAY : `RESP_SLVERR))
      else $error("write response code wrong");
   a_rresp_map: assert property ($rose(s_axi_rvalid) |-> s_axi_rdata[31:4] == 28'h0 &&
      s_axi_rresp == ((kind(ra_reg) != 2'h0) ? `RESP_OKAY : `RESP_SLVERR) &&
      (kind(ra_reg) == 2'h2 || s_axi_rdata == 32'h0))
      else $error("read response wrong");
   a_reset_quiet: assert property ($rose(aresetn) |->
      !s_axi_bvalid && !s_axi_rvalid && !irq && serial_out_pin_oe_n)
      else $error("outputs active after reset");
   a_out_enable: assert property ($rose(s_axi_bvalid) && kind(wa_reg) == 2'h1 &&
      wa_reg[ADDR_W-1:2] == `IDX_PIN_MODE |-> serial_out_pin_oe_n == !wd0_reg)
      else $error("data out enable wrong");
endmodule // serial_if_asserts
`default_nettype wire

//--- serial_if_defines.vh
/*
 Constants for the clock-synchronous serial interface: register indices,
 field positions, reset values and timing counts.
 Assumes a 32-bit AXI4-Lite bus with one aligned word per register.
*/
`ifndef SERIAL_IF_DEFINES_VH
`define SERIAL_IF_DEFINES_VH

// register indices as printed, byte address is four times the index
`define IDX_PIN_MODE 12'h004
`define IDX_MODE_A 12'h005
`define IDX_DATA_LOW 12'h006
`define IDX_DATA_HIGH 12'h007
`define IDX_MISC 12'h00C
`define IDX_MODE_B 12'h028
`define IDX_START 12'h040
`define IDX_IRQ_STATUS 12'h041
`define IDX_IRQ_ENABLE 12'h042
`define IDX_IRQ_CLEAR 12'h043

// field positions
`define PIN_MODE_TX_BIT 0
`define PIN_MODE_RX_BIT 1
`define MODE_A_PIN_BIT 3
`define MODE_B_RANGE_BIT 0
`define MODE_B_IDLE_BIT 1
`define DONE_FLAG_BIT 2

// clock source codes of the prescaler select bits
`define SRC_SYSTEM 3'h6
`define SRC_EXTERNAL 3'h7

// operating modes of the pin mode bits
`define OPMODE_CONT_CLOCK 2'h0

// reset values
`define RST_NIBBLE 4'h0
`define RST_DATA 8'h00
`define RST_SERIAL_OUT 1'b1

// bit count of one transfer and mode write latency in instruction cycles
`define BITS_PER_WORD 8
`define LAST_BIT_COUNT 3'h7
`define MODE_A_LATENCY 2

// instruction cycle time in ns and the clock period it maps to
`define INSTR_CYCLE_NS 10
`define CLK_PERIOD_NS 10
`define CYCLES_PER_INSTR (`INSTR_CYCLE_NS / `CLK_PERIOD_NS)

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- serial_if_tb_top.sv
/*
 testbench for serial_if: register access over axi4-lite, internal and
 external clock transfers, prescaler periods, aborts and interrupts.
 assumes serial_peer as the far side and the checker bound below.
*/
`timescale 1ns/1ns
`default_nettype none
`include "serial_if_defines.vh"
module serial_if_tb_top;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire awready, wready, bvalid, arready, rvalid, sck_out, sck_oe_n, so, so_oe_n;
   wire irq, si, ext_sck, sck_w;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int error_cnt = 0;
   int tests_run = 0;
   int per;
   logic [31:0] rd;
   logic [1:0] rs;
   logic [11:0] idx_tab [9] = '{`IDX_DATA_LOW, `IDX_DATA_HIGH, `IDX_MISC, `IDX_MODE_B,
      `IDX_IRQ_STATUS, `IDX_IRQ_ENABLE, `IDX_PIN_MODE, `IDX_MODE_A, `IDX_IRQ_CLEAR};
   assign sck_w = sck_oe_n ? ext_sck : sck_out;
   always #5 aclk = ~aclk;
   serial_if #(.ADDR_W(12)) serial_if_inst (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck_out),
      .serial_clock_pin_oe_n(sck_oe_n), .serial_in_pin(si), .serial_out_pin(so),
      .serial_out_pin_oe_n(so_oe_n), .irq(irq));
   serial_peer serial_peer_inst (.aclk(aclk), .sck(sck_w), .so(so), .si(si), .ext_sck(ext_sck));
   task automatic end_of_test;
      $display("mismatches %0d, checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(inout int c, input int lim);
      @(posedge aclk);
      c++;
      if (c > lim) begin
         error_cnt++;
         end_of_test();
      end
   endtask
   task automatic wr(input logic [11:0] idx, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      awaddr <= {idx[9:0], 2'b00};
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'b111;
      forever begin
         tick(n, 300);
         if (bvalid === 1'b1) break;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end
      check("bresp", 32'(bresp), 32'(er));
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rchk(input string nm, input logic [11:0] idx, input logic [31:0] e);
      int n;
      n = 0;
      araddr <= {idx[9:0], 2'b00};
      {arvalid, rready} <= 2'b11;
      forever begin
         tick(n, 300);
         if (rvalid === 1'b1) break;
         if (arready === 1'b1) arvalid <= 1'b0;
      end
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
      @(posedge aclk);
      check(nm, rd, e);
   endtask
   task automatic wait_irq(input int lim);
      int n;
      n = 0;
      while (irq !== 1'b1) tick(n, lim);
   endtask
   task automatic next_rise(output int c);
      c = 0;
      while (sck_out !== 1'b0) tick(c, 20000);
      while (sck_out !== 1'b1) tick(c, 20000);
   endtask
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      foreach (idx_tab[i]) rchk("reset value", idx_tab[i], 32'h0);
      rchk("unmapped data", 12'h0FF, 32'h0);
      check("unmapped rresp", 32'(rs), 32'(`RESP_SLVERR));
      wr(12'h0FF, 32'h1, `RESP_SLVERR);
      wr(`IDX_PIN_MODE, 32'h1, `RESP_OKAY);
      check("out enable", 32'(so_oe_n), 32'h0);
      wr(`IDX_MODE_B, 32'h2, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      check("idle high", 32'(so), 32'h1);
      wr(`IDX_MODE_B, 32'h0, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      check("idle low", 32'(so), 32'h0);
      wr(`IDX_DATA_LOW, 32'hFFFFFFF5, `RESP_OKAY);
      wr(`IDX_DATA_HIGH, 32'hA, `RESP_OKAY);
      rchk("data low", `IDX_DATA_LOW, 32'h5);
      rchk("data high", `IDX_DATA_HIGH, 32'hA);
      wr(`IDX_MISC, 32'h9, `RESP_OKAY);
      rchk("misc", `IDX_MISC, 32'h9);
      wr(`IDX_IRQ_ENABLE, 32'h4, `RESP_OKAY);
      rchk("irq enable", `IDX_IRQ_ENABLE, 32'h4);
      // transmit only, prescaler divide by two; start issued after the mode write settles
      wr(`IDX_MODE_A, 32'hD, `RESP_OKAY);
      serial_peer_inst.load(8'h00);
      wr(`IDX_START, 32'h1, `RESP_OKAY);
      wait_irq(300);
      check("sent byte", 32'(serial_peer_inst.rx_reg), 32'hA5);
      rchk("status", `IDX_IRQ_STATUS, 32'h4);
      rchk("rx off low", `IDX_DATA_LOW, 32'h0);
      rchk("rx off high", `IDX_DATA_HIGH, 32'h0);
      wr(`IDX_IRQ_CLEAR, 32'h4, `RESP_OKAY);
      check("irq cleared", 32'(irq), 32'h0);
      wr(`IDX_MODE_A, 32'hD, `RESP_OKAY);
      rchk("idle after end", `IDX_IRQ_STATUS, 32'h0);
      // external clock, both directions
      wr(`IDX_PIN_MODE, 32'h3, `RESP_OKAY);
      wr(`IDX_MODE_A, 32'hF, `RESP_OKAY);
      wr(`IDX_START, 32'h1, `RESP_OKAY);
      check("clock pin input", 32'(sck_oe_n), 32'h1);
      serial_peer_inst.ext_frame(3, 8);
      wr(`IDX_START, 32'h1, `RESP_OKAY);
      rchk("restart flag", `IDX_IRQ_STATUS, 32'h4);
      wr(`IDX_IRQ_CLEAR, 32'h4, `RESP_OKAY);
      wr(`IDX_DATA_LOW, 32'hC, `RESP_OKAY);
      wr(`IDX_DATA_HIGH, 32'h3, `RESP_OKAY);
      serial_peer_inst.load(8'h96);
      serial_peer_inst.ext_frame(7, 8);
      repeat (6) @(posedge aclk);
      rchk("seven clocks", `IDX_IRQ_STATUS, 32'h0);
      serial_peer_inst.ext_frame(1, 8);
      wait_irq(50);
      check("sent byte", 32'(serial_peer_inst.rx_reg), 32'h3C);
      rchk("rx low", `IDX_DATA_LOW, 32'h6);
      rchk("rx high", `IDX_DATA_HIGH, 32'h9);
      wr(`IDX_IRQ_CLEAR, 32'h4, `RESP_OKAY);
      serial_peer_inst.ext_frame(1, 8);
      repeat (6) @(posedge aclk);
      wr(`IDX_MODE_A, 32'hF, `RESP_OKAY);
      rchk("rewait abort", `IDX_IRQ_STATUS, 32'h4);
      wr(`IDX_IRQ_CLEAR, 32'h4, `RESP_OKAY);
      // every prescaler code in both ranges, then abort
      for (int r = 0; r < 2; r++) begin
         for (int c = 0; c < 6; c++) begin
            wr(`IDX_MODE_B, 32'(r), `RESP_OKAY);
            wr(`IDX_MODE_A, 32'(8 + c), `RESP_OKAY);
            wr(`IDX_START, 32'h1, `RESP_OKAY);
            next_rise(per);
            next_rise(per);
            check("period", 32'(per), 32'(((r == 1 ? 4096 : 2048) >> (2 * c)) * 2));
            wr(r == 0 ? `IDX_MODE_A : `IDX_START, 32'h8, `RESP_OKAY);
            rchk("abort flag", `IDX_IRQ_STATUS, 32'h4);
            wr(`IDX_MODE_A, 32'h0, `RESP_OKAY);
            wr(`IDX_IRQ_CLEAR, 32'h4, `RESP_OKAY);
         end
      end
      // continuous clock output
      wr(`IDX_MODE_B, 32'h0, `RESP_OKAY);
      wr(`IDX_PIN_MODE, 32'h0, `RESP_OKAY);
      wr(`IDX_MODE_A, 32'hE, `RESP_OKAY);
      wr(`IDX_START, 32'h1, `RESP_OKAY);
      repeat (12) next_rise(per);
      check("system period", 32'(per), 32'h2);
      rchk("continuous", `IDX_IRQ_STATUS, 32'h0);
      wr(`IDX_MODE_A, 32'h0, `RESP_OKAY);
      end_of_test();
   end
endmodule // serial_if_tb_top
bind serial_if serial_if_asserts #(.ADDR_W(ADDR_W)) serial_if_asserts_inst (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .serial_out_pin_oe_n(serial_out_pin_oe_n), .irq(irq));
`default_nettype wire

//--- serial_peer.sv
/*
 model of the external serial device: samples data on rising clock edges,
 drives its data after falling edges, and can make the clock itself.
 assumes the bench resolves the shared clock wire into sck.
*/
`timescale 1ns/1ns
`default_nettype none
module serial_peer (
   // clock
   input wire logic aclk,
   // serial wires
   input wire logic sck,
   input wire logic so,
   output logic si,
   output logic ext_sck
);
   logic [7:0] tx_reg = 8'h00;
   logic [7:0] rx_reg = 8'h00;
   int bit_idx = 0;
   initial si = 1'b1;
   initial ext_sck = 1'b1;
   always @(posedge sck) begin
      rx_reg = {so, rx_reg[7:1]};
   end
   always @(negedge sck) begin
      // released after the last bit: shows the inverse
      si <= (bit_idx < 8) ? tx_reg[bit_idx[2:0]] : ~si;
      bit_idx = bit_idx + 1;
   end
   task load(input logic [7:0] b);
      tx_reg = b;
      rx_reg = 8'h00;
      bit_idx = 0;
   endtask
   task ext_frame(input int n, input int half);
      for (int i = 0; i < n; i++) begin
         ext_sck <= 1'b0;
         repeat (half) @(posedge aclk);
         ext_sck <= 1'b1;
         repeat (half) @(posedge aclk);
      end
   endtask
endmodule // serial_peer
`default_nettype wire

//--- transmit_clock_gen.v
/*
 Internal transmit clock generator: divides the instruction clock by twice the
 selected prescaler ratio, or by two for the system clock source.
 Assumes enable is low whenever no internal clock is wanted; the output then
 idles high and the next enable starts with a falling edge.
*/
`timescale 1ns/1ns
`default_nettype none
`include "serial_if_defines.vh"

module transmit_clock_gen #(
   parameter CNT_W = 13
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // control
   input wire enable,
   input wire [2:0] select,
   input wire range,
   // generated clock
   output reg clock_level,
   output reg fall_pulse,
   output reg rise_pulse
);

   reg [CNT_W-1:0] count_reg;
   wire [CNT_W-1:0] half_period;

   // half period in instruction cycles: the prescaler ratio
   function [CNT_W-1:0] ratio;
      input [2:0] sel;
      input rng;
      reg [CNT_W-1:0] base;
      begin
         case (sel)
            3'h0: base = 13'h0800;
            3'h1: base = 13'h0200;
            3'h2: base = 13'h0080;
            3'h3: base = 13'h0020;
            3'h4: base = 13'h0008;
            3'h5: base = 13'h0002;
            default: base = 13'h0001;
         endcase
         if (sel != `SRC_SYSTEM && rng) begin
            ratio = {base[CNT_W-2:0], 1'b0};
         end else begin
            ratio = base;
         end
      end
   endfunction

   assign half_period = ratio(select, range);

   always @(posedge aclk) begin
      if (!aresetn) begin
         count_reg <= {CNT_W{1'b0}};
         clock_level <= 1'b1;
         fall_pulse <= 1'b0;
         rise_pulse <= 1'b0;
      end else if (!enable) begin
         count_reg <= {CNT_W{1'b0}};
         clock_level <= 1'b1;
         fall_pulse <= 1'b0;
         rise_pulse <= 1'b0;
      end else if (count_reg == half_period - 13'h0001) begin
         count_reg <= {CNT_W{1'b0}};
         clock_level <= ~clock_level;
         fall_pulse <= clock_level;
         rise_pulse <= ~clock_level;
      end else begin
         count_reg <= count_reg + 13'h0001;
         fall_pulse <= 1'b0;
         rise_pulse <= 1'b0;
      end
   end

endmodule // transmit_clock_gen

`default_nettype wire
